// *** pkg/bts_pkg.sv ***
package bts_pkg;

  // Register indices; the byte address on the bus is four times the index
  localparam logic [7:0] IDX_RED_TARGET   = 8'h1d;
  localparam logic [7:0] IDX_GREEN_TARGET = 8'h1e;
  localparam logic [7:0] IDX_BLUE_TARGET  = 8'h1f;
  localparam logic [7:0] IDX_CLAMP        = 8'h23;
  localparam logic [7:0] IDX_SYNC_CTRL    = 8'h25;
  localparam logic [7:0] IDX_COLOUR_CFG   = 8'h05;

  localparam logic [7:0] RST_TARGET    = 8'h00;
  localparam logic [7:0] RST_CLAMP     = 8'h18;
  localparam logic [7:0] RST_SYNC_CTRL = 8'h00;
  localparam logic [7:0] RST_COLOUR    = 8'h00;

  localparam int CLAMP_LSB       = 4;
  localparam int CLAMP_MSB       = 6;
  localparam int SYNC_TRISTATE   = 0;
  localparam int SYNC_HOLD_POL   = 1;
  localparam int SYNC_LEAD_LOCK  = 2;
  localparam int SYNC_RAW_FRAME  = 4;
  localparam int COLOUR_COMP_BIT = 2;

  localparam logic [7:0] BLACK_ZERO = 8'h00;
  localparam logic [7:0] BLACK_MID  = 8'h80;

  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } bts_codes_s;

  typedef struct packed {
    logic       tristate;
    logic       hold_active_low;
    logic       lead_edge_lock;
    logic       frame_raw;
  } bts_sync_cfg_s;

endpackage

// *** core/bts_regs.sv ***
`timescale 1ns/1ps
// Summary of operation
// - Per-channel 8-bit signed black target register
// - RGB red/blue servo to zero plus target
// - Component red/blue servo to 0x80 plus target
// - Green always servos to zero plus target
// - Targets coexist with digital offset adder
// - Shared 3-bit clamp strength, zero disconnects
// - Sync control bit0 tristates all sync outputs
// - Bit1 sets hold input polarity
// - Bit2 picks locked edge of line sync
// - Bit4 selects aligned or raw frame sync
// - Config 0x05 bit2 enables component mode
module bts_regs (
  input  wire logic                   MCLK,
  input  wire logic                   RST_N,
  input  wire logic                   WB_CYC_I,
  input  wire logic                   WB_STB_I,
  input  wire logic                   WB_WE_I,
  input  wire logic [9:0]             WB_ADR_I,
  input  wire logic [3:0]             WB_SEL_I,
  input  wire logic [31:0]            WB_DAT_I,
  output logic      [31:0]            WB_DAT_O,
  output logic                        WB_ACK_O,
  output logic                        WB_ERR_O,
  output bts_pkg::bts_codes_s         BLACK_TARGET,
  output bts_pkg::bts_codes_s         BLACK_REFERENCE,
  output logic                        COMPONENT_MODE,
  output logic      [2:0]             CLAMP_STRENGTH,
  output bts_pkg::bts_sync_cfg_s      SYNC_CFG,
  output logic                        SYNC_OUT_EN
);

  logic [7:0] red_black_target;
  logic [7:0] green_black_target;
  logic [7:0] blue_black_target;
  logic [7:0] restore_clamp_strength;
  logic [7:0] sync_output_control;
  logic [7:0] colour_config;
  logic       ack;
  logic       err;
  logic [31:0] rdata;
  bts_pkg::bts_codes_s black_reference;
  bts_pkg::bts_codes_s next_black_reference;

  wire        req      = WB_CYC_I & WB_STB_I & ~ack & ~err;
  wire [7:0]  idx      = WB_ADR_I[9:2];
  wire        sel_red  = idx == bts_pkg::IDX_RED_TARGET;
  wire        sel_grn  = idx == bts_pkg::IDX_GREEN_TARGET;
  wire        sel_blu  = idx == bts_pkg::IDX_BLUE_TARGET;
  wire        sel_clmp = idx == bts_pkg::IDX_CLAMP;
  wire        sel_sync = idx == bts_pkg::IDX_SYNC_CTRL;
  wire        sel_col  = idx == bts_pkg::IDX_COLOUR_CFG;
  wire        mapped   = sel_red | sel_grn | sel_blu | sel_clmp | sel_sync | sel_col;
  wire        wr_lane  = req & mapped & WB_WE_I & WB_SEL_I[0];
  wire [7:0]  wbyte    = WB_DAT_I[7:0];

  // Byte-wide register with byte-lane write; all bits kept verbatim
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      red_black_target       <= bts_pkg::RST_TARGET;
      green_black_target     <= bts_pkg::RST_TARGET;
      blue_black_target      <= bts_pkg::RST_TARGET;
      restore_clamp_strength <= bts_pkg::RST_CLAMP;
      sync_output_control    <= bts_pkg::RST_SYNC_CTRL;
      colour_config          <= bts_pkg::RST_COLOUR;
    end else if (wr_lane) begin
      if (sel_red) red_black_target <= wbyte;
      if (sel_grn) green_black_target <= wbyte;
      if (sel_blu) blue_black_target <= wbyte;
      if (sel_clmp) restore_clamp_strength <= wbyte;
      if (sel_sync) sync_output_control <= wbyte;
      if (sel_col) colour_config <= wbyte;
    end
  end

  wire [7:0] rbyte = sel_red  ? red_black_target :
                     sel_grn  ? green_black_target :
                     sel_blu  ? blue_black_target :
                     sel_clmp ? restore_clamp_strength :
                     sel_sync ? sync_output_control :
                     sel_col  ? colour_config : 8'h00;

  // Single-wait-state answer; unmapped index gives err
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      ack   <= 1'b0;
      err   <= 1'b0;
      rdata <= 32'h0000_0000;
    end else begin
      ack   <= req & mapped;
      err   <= req & ~mapped;
      rdata <= (req & mapped & ~WB_WE_I) ? {24'h00_0000, rbyte} : 32'h0000_0000;
    end
  end

  assign WB_ACK_O = ack;
  assign WB_ERR_O = err;
  assign WB_DAT_O = rdata;

  assign COMPONENT_MODE = colour_config[bts_pkg::COLOUR_COMP_BIT];

  // Raw targets go out unchanged; the offset adder downstream stays separate
  assign BLACK_TARGET.red   = red_black_target;
  assign BLACK_TARGET.green = green_black_target;
  assign BLACK_TARGET.blue  = blue_black_target;

  // Servo code for one channel; mid-scale base only for colour-difference channels
  function automatic logic [7:0] servo_code(input logic mid_base, input logic [7:0] target);
    logic [7:0] base;
    base = mid_base ? bts_pkg::BLACK_MID : bts_pkg::BLACK_ZERO;
    return 8'(base + target);
  endfunction

  assign next_black_reference.red   = servo_code(COMPONENT_MODE, red_black_target);
  assign next_black_reference.green = servo_code(1'b0, green_black_target);
  assign next_black_reference.blue  = servo_code(COMPONENT_MODE, blue_black_target);

  // Registered so the servo never sees a half-updated code
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      black_reference <= '{red: bts_pkg::RST_TARGET, green: bts_pkg::RST_TARGET,
                           blue: bts_pkg::RST_TARGET};
    end else begin
      black_reference <= next_black_reference;
    end
  end

  assign BLACK_REFERENCE = black_reference;

  assign CLAMP_STRENGTH = restore_clamp_strength[bts_pkg::CLAMP_MSB:bts_pkg::CLAMP_LSB];

  assign SYNC_CFG.tristate        = sync_output_control[bts_pkg::SYNC_TRISTATE];
  assign SYNC_CFG.hold_active_low = sync_output_control[bts_pkg::SYNC_HOLD_POL];
  assign SYNC_CFG.lead_edge_lock  = sync_output_control[bts_pkg::SYNC_LEAD_LOCK];
  assign SYNC_CFG.frame_raw       = sync_output_control[bts_pkg::SYNC_RAW_FRAME];
  assign SYNC_OUT_EN = ~sync_output_control[bts_pkg::SYNC_TRISTATE];

  property p_ack_one;
    @(posedge MCLK) disable iff (!RST_N)
      WB_ACK_O |=> !WB_ACK_O;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");

  property p_ack_time;
    @(posedge MCLK) disable iff (!RST_N)
      (req & mapped) |=> WB_ACK_O;
  endproperty
  a_ack_time: assert property (p_ack_time) else $error("mapped access not acked");

  property p_write_target;
    @(posedge MCLK) disable iff (!RST_N)
      (wr_lane & sel_red) |=> BLACK_TARGET.red == $past(WB_DAT_I[7:0]);
  endproperty
  a_write_target: assert property (p_write_target) else $error("red target not stored");

  property p_rgb_ref;
    @(posedge MCLK) disable iff (!RST_N)
      !COMPONENT_MODE |=> BLACK_REFERENCE.red == $past(red_black_target);
  endproperty
  a_rgb_ref: assert property (p_rgb_ref) else $error("rgb red reference wrong");

  property p_comp_ref;
    @(posedge MCLK) disable iff (!RST_N)
      COMPONENT_MODE |=> BLACK_REFERENCE.blue == 8'($past(blue_black_target) + bts_pkg::BLACK_MID);
  endproperty
  a_comp_ref: assert property (p_comp_ref) else $error("component blue reference wrong");

  property p_green_ref;
    @(posedge MCLK) disable iff (!RST_N)
      BLACK_REFERENCE.green == $past(BLACK_TARGET.green);
  endproperty
  a_green_ref: assert property (p_green_ref) else $error("green reference wrong");

  property p_clamp;
    @(posedge MCLK) disable iff (!RST_N)
      (wr_lane & sel_clmp) |=> CLAMP_STRENGTH == $past(WB_DAT_I[6:4]);
  endproperty
  a_clamp: assert property (p_clamp) else $error("clamp field wrong");

  property p_tristate;
    @(posedge MCLK) disable iff (!RST_N)
      (wr_lane & sel_sync) |=> SYNC_OUT_EN == !$past(WB_DAT_I[0]);
  endproperty
  a_tristate: assert property (p_tristate) else $error("sync enable wrong");

  property p_readback;
    @(posedge MCLK) disable iff (!RST_N)
      (req & sel_sync & !WB_WE_I) |=> WB_DAT_O[7:0] == sync_output_control;
  endproperty
  a_readback: assert property (p_readback) else $error("readback wrong");

  property p_sync_bits;
    @(posedge MCLK) disable iff (!RST_N)
      (wr_lane & sel_sync) |=> SYNC_CFG.frame_raw == $past(WB_DAT_I[4])
        && SYNC_CFG.lead_edge_lock == $past(WB_DAT_I[2])
        && SYNC_CFG.hold_active_low == $past(WB_DAT_I[1]);
  endproperty
  a_sync_bits: assert property (p_sync_bits) else $error("sync bits wrong");

  property p_err_one;
    @(posedge MCLK) disable iff (!RST_N)
      WB_ERR_O |=> !WB_ERR_O;
  endproperty
  a_err_one: assert property (p_err_one) else $error("err longer than one cycle");

  property p_err_time;
    @(posedge MCLK) disable iff (!RST_N)
      (req & ~mapped) |=> WB_ERR_O && !WB_ACK_O;
  endproperty
  a_err_time: assert property (p_err_time) else $error("unmapped access not refused");

  property p_ack_err_excl;
    @(posedge MCLK) disable iff (!RST_N)
      !(WB_ACK_O && WB_ERR_O);
  endproperty
  a_ack_err_excl: assert property (p_ack_err_excl) else $error("ack and err together");

  property p_idle_dat;
    @(posedge MCLK) disable iff (!RST_N)
      !WB_ACK_O |-> WB_DAT_O == 32'h0000_0000;
  endproperty
  a_idle_dat: assert property (p_idle_dat) else $error("read data outside ack");

  property p_upper_zero;
    @(posedge MCLK) disable iff (!RST_N)
      WB_ACK_O |-> WB_DAT_O[31:8] == 24'h00_0000;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper read bytes not zero");

  property p_write_no_data;
    @(posedge MCLK) disable iff (!RST_N)
      (req & mapped & WB_WE_I) |=> WB_DAT_O == 32'h0000_0000;
  endproperty
  a_write_no_data: assert property (p_write_no_data) else $error("data on write ack");

  property p_write_green;
    @(posedge MCLK) disable iff (!RST_N)
      (wr_lane & sel_grn) |=> BLACK_TARGET.green == $past(WB_DAT_I[7:0]);
  endproperty
  a_write_green: assert property (p_write_green) else $error("green target not stored");

  property p_write_blue;
    @(posedge MCLK) disable iff (!RST_N)
      (wr_lane & sel_blu) |=> BLACK_TARGET.blue == $past(WB_DAT_I[7:0]);
  endproperty
  a_write_blue: assert property (p_write_blue) else $error("blue target not stored");

  property p_target_hold;
    @(posedge MCLK) disable iff (!RST_N)
      !wr_lane |=> $stable(BLACK_TARGET);
  endproperty
  a_target_hold: assert property (p_target_hold) else $error("target changed unwritten");

  property p_target_readback;
    @(posedge MCLK) disable iff (!RST_N)
      (req & sel_red & !WB_WE_I) |=> WB_DAT_O[7:0] == $past(red_black_target);
  endproperty
  a_target_readback: assert property (p_target_readback) else $error("target readback wrong");

  property p_sel_masked;
    @(posedge MCLK) disable iff (!RST_N)
      (req & mapped & WB_WE_I & !WB_SEL_I[0]) |=> $stable(BLACK_TARGET)
        && $stable(CLAMP_STRENGTH) && $stable(SYNC_CFG) && $stable(COMPONENT_MODE);
  endproperty
  a_sel_masked: assert property (p_sel_masked) else $error("masked write changed state");

  property p_unmapped_keep;
    @(posedge MCLK) disable iff (!RST_N)
      (req & ~mapped) |=> $stable(BLACK_TARGET)
        && $stable(CLAMP_STRENGTH) && $stable(SYNC_CFG) && $stable(COMPONENT_MODE);
  endproperty
  a_unmapped_keep: assert property (p_unmapped_keep) else $error("unmapped write stored");

  property p_rgb_blue;
    @(posedge MCLK) disable iff (!RST_N)
      !COMPONENT_MODE |=> BLACK_REFERENCE.blue == $past(blue_black_target);
  endproperty
  a_rgb_blue: assert property (p_rgb_blue) else $error("rgb blue reference wrong");

  property p_comp_red;
    @(posedge MCLK) disable iff (!RST_N)
      COMPONENT_MODE |=> BLACK_REFERENCE.red == 8'($past(red_black_target) + bts_pkg::BLACK_MID);
  endproperty
  a_comp_red: assert property (p_comp_red) else $error("component red reference wrong");

  property p_offset_free;
    @(posedge MCLK) disable iff (!RST_N)
      $rose(COMPONENT_MODE) |-> $stable(BLACK_TARGET);
  endproperty
  a_offset_free: assert property (p_offset_free) else $error("mode change moved target");

  property p_mode_write;
    @(posedge MCLK) disable iff (!RST_N)
      (wr_lane & sel_col) |=> COMPONENT_MODE == $past(WB_DAT_I[bts_pkg::COLOUR_COMP_BIT]);
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("colour mode not stored");

  property p_mode_hold;
    @(posedge MCLK) disable iff (!RST_N)
      !(wr_lane & sel_col) |=> $stable(COMPONENT_MODE);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("colour mode changed");

  property p_clamp_hold;
    @(posedge MCLK) disable iff (!RST_N)
      !(wr_lane & sel_clmp) |=> $stable(CLAMP_STRENGTH);
  endproperty
  a_clamp_hold: assert property (p_clamp_hold) else $error("clamp changed unwritten");

  property p_clamp_readback;
    @(posedge MCLK) disable iff (!RST_N)
      (req & sel_clmp & !WB_WE_I) |=> WB_DAT_O[7:0] == $past(restore_clamp_strength);
  endproperty
  a_clamp_readback: assert property (p_clamp_readback) else $error("clamp readback wrong");

  property p_sync_hold;
    @(posedge MCLK) disable iff (!RST_N)
      !(wr_lane & sel_sync) |=> $stable(SYNC_CFG) && $stable(SYNC_OUT_EN);
  endproperty
  a_sync_hold: assert property (p_sync_hold) else $error("sync control changed");

  property p_en_inverse;
    @(posedge MCLK) disable iff (!RST_N)
      SYNC_OUT_EN == !SYNC_CFG.tristate;
  endproperty
  a_en_inverse: assert property (p_en_inverse) else $error("sync enable not inverse");

  property p_lead_lock;
    @(posedge MCLK) disable iff (!RST_N)
      (wr_lane & sel_sync) |=> SYNC_CFG.lead_edge_lock == $past(WB_DAT_I[bts_pkg::SYNC_LEAD_LOCK]);
  endproperty
  a_lead_lock: assert property (p_lead_lock) else $error("lock edge bit wrong");

  property p_frame_raw;
    @(posedge MCLK) disable iff (!RST_N)
      (wr_lane & sel_sync) |=> SYNC_CFG.frame_raw == $past(WB_DAT_I[bts_pkg::SYNC_RAW_FRAME]);
  endproperty
  a_frame_raw: assert property (p_frame_raw) else $error("frame mode bit wrong");

  c_write: cover property (@(posedge MCLK) wr_lane);
  c_err: cover property (@(posedge MCLK) WB_ERR_O);
  c_comp: cover property (@(posedge MCLK) COMPONENT_MODE && SYNC_CFG.tristate);
  c_masked: cover property (@(posedge MCLK) req & mapped & WB_WE_I & !WB_SEL_I[0]);
  c_comp_neg: cover property (@(posedge MCLK) COMPONENT_MODE && BLACK_TARGET.red[7]);

endmodule

// *** tb/bts_rx.sv ***
`timescale 1ns/1ps
module bts_rx (
  input  wire logic                   mclk,
  input  wire bts_pkg::bts_sync_cfg_s sync_cfg,
  input  wire logic                   sync_out_en,
  output logic                        driven
);
  // Sees the sync lines only while not three-stated
  always_ff @(posedge mclk) begin
    driven <= sync_out_en & ~sync_cfg.tristate;
  end
endmodule

// *** tb/black_target_sync_output_ctrl_bench.sv ***
`timescale 1ns/1ps
module black_target_sync_output_ctrl_bench;
  logic                   mclk = 1'b0;
  logic                   rst_n = 1'b0;
  logic                   cyc = 1'b0;
  logic                   stb = 1'b0;
  logic                   we = 1'b0;
  logic [9:0]             adr = '0;
  logic [3:0]             sel = '0;
  logic [31:0]            dat_i = '0;
  logic [31:0]            dat_o;
  logic                   ack, err, comp, en, driven, e;
  logic [2:0]             clamp;
  logic [7:0]             q;
  bts_pkg::bts_codes_s    tgt, bref;
  bts_pkg::bts_sync_cfg_s scfg;
  int                     err_total = 0, checked = 0, seed = 24;
  logic [9:0]             ad [6];
  logic [7:0]             mdl [6];
  logic [7:0]             rv [6] = '{8'h00, 8'h00, 8'h00, 8'h18, 8'h00, 8'h00};
  logic [7:0]             msk [6] = '{8'hff, 8'hff, 8'hff, 8'h70, 8'h17, 8'hff};
  always #50 mclk = ~mclk;
  bts_regs u_bts_regs (.MCLK(mclk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o),
    .WB_ACK_O(ack), .WB_ERR_O(err), .BLACK_TARGET(tgt), .BLACK_REFERENCE(bref),
    .COMPONENT_MODE(comp), .CLAMP_STRENGTH(clamp), .SYNC_CFG(scfg), .SYNC_OUT_EN(en));
  bts_rx u_bts_rx (.mclk(mclk), .sync_cfg(scfg), .sync_out_en(en), .driven(driven));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [9:0] a, input logic [7:0] d, input logic s);
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= {3'b000, s};
    dat_i <= {24'h0, d};
    do begin
      @(posedge mclk);
    end while (ack !== 1'b1 && err !== 1'b1);
    q = dat_o[7:0];
    e = err;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic outs;
    logic [7:0] off;
    off = mdl[5][2] ? 8'h80 : 8'h00;
    @(negedge mclk);
    chk(tgt, {mdl[0], mdl[1], mdl[2]});
    chk(bref, {mdl[0] + off, mdl[1], mdl[2] + off});
    chk(comp, mdl[5][2]);
    chk(clamp, mdl[3][6:4]);
    chk(scfg, {mdl[4][0], mdl[4][1], mdl[4][2], mdl[4][4]});
    chk(en, !mdl[4][0]);
    chk(driven, !mdl[4][0]);
  endtask
  task automatic tally_and_finish;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #(100 * 5000);
    err_total++;
    tally_and_finish();
  end
  initial begin
    logic [7:0] v;
    logic       s;
    ad = '{{bts_pkg::IDX_RED_TARGET, 2'b00}, {bts_pkg::IDX_GREEN_TARGET, 2'b00},
      {bts_pkg::IDX_BLUE_TARGET, 2'b00}, {bts_pkg::IDX_CLAMP, 2'b00},
      {bts_pkg::IDX_SYNC_CTRL, 2'b00}, {bts_pkg::IDX_COLOUR_CFG, 2'b00}};
    mdl = rv;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      wb(1'b0, ad[i], 8'h00, 1'b1);
      chk({e, q}, {1'b0, rv[i]});
    end
    outs();
    for (int k = 0; k < 12; k++) begin
      for (int i = 0; i < 6; i++) begin
        v = 8'($random(seed));
        v = (v & msk[i]) | ((i == 3) ? 8'h08 : 8'h00);
        s = (k != 5);
        wb(1'b1, ad[i], v, s);
        if (s) mdl[i] = v;
        wb(1'b0, ad[i], 8'h00, 1'b1);
        chk({e, q}, {1'b0, mdl[i]});
        outs();
      end
    end
    wb(1'b1, 10'h3fc, 8'h5a, 1'b1);
    chk(e, 1'b1);
    outs();
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    mdl = rv;
    outs();
    tally_and_finish();
  end
endmodule
